// [cprc_defines.svh]
// Constants for the clock, power and reset control block.
`ifndef CPRC_DEFINES_SVH
`define CPRC_DEFINES_SVH
`define CPRC_STATES_PER_CYCLE 3'd6
`define CPRC_PHASES_PER_STATE 2
`define CPRC_OSC_DIV 2
`define CPRC_SAMPLE_STATE 3'd4
`define CPRC_RST_HOLD_CYCLES 2'd2
`define CPRC_PORT_RESET 8'hFF
`define CPRC_SP_RESET 8'h07
`define CPRC_POWER_CONTROL_REG_RESET 8'h00
`define CPRC_SFR_RESET 8'h00
`define CPRC_POWER_CONTROL_REG_IDLE_BIT 0
`define CPRC_POWER_CONTROL_REG_PD_BIT 1
`define CPRC_POWER_CONTROL_REG_POF_BIT 4
`endif

// [cprc_pkg.sv]
// Types for the clock, power and reset control block.
package cprc_pkg;
   typedef enum logic [2:0] {
      CPRC_RUN  = 3'b001,
      CPRC_IDLE = 3'b010,
      CPRC_PD   = 3'b100
   } cprc_mode_t;
endpackage

// [cprc_glitch_filter.sv]
// Reset pin glitch filter: output follows only a level held for N samples.
`timescale 1ns/1ps
`default_nettype none
module cprc_glitch_filter #(
   parameter int N = 2
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_sample,
   input  wire logic i_level,
   output logic      o_level
);
   logic [1:0] cnt_r;
   logic       lvl_r;
   wire        differs = (i_level != lvl_r);
   wire        full    = (cnt_r == 2'(N - 1));

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= 2'h0;
         lvl_r <= 1'b0;
      end else if (i_sample) begin
         cnt_r <= (differs && !full) ? cnt_r + 2'h1 : 2'h0;
         if (differs && full)
            lvl_r <= i_level;
      end
   end

   assign o_level = lvl_r;
endmodule
`default_nettype wire

// [cprc_top.sv]
// Clock division, idle and power-down control, and reset sequencing.
`timescale 1ns/1ps
`default_nettype none
`include "cprc_defines.svh"

// Notes on behaviour
// - The oscillator clock is halved before any internal timing uses it.
// - Writing one to the idle request bit enters idle mode.
// - In idle the core clock is gated while peripherals stay clocked.
// - Any interrupt or a reset ends idle mode.
// - Setting the power-down bit stops every clock and the oscillator.
// - Only a reset leaves power-down; interrupts do not.
// - The reset pin is sampled once per machine cycle at state 5 phase 2.
// - Short glitches on the reset pin are filtered out.
// - Reset loads every port latch with all ones.
// - Reset loads the stack pointer with seven.
// - Reset clears the power control register except bit 4.
// - Power-up sets the power-on flag in hardware.
// - Software may set and clear the power-on flag.
module cprc_top (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_rst_pin,
   input  wire logic       i_power_control_reg_we,
   input  wire logic [7:0] i_power_control_reg_wdata,
   input  wire logic       i_irq,
   output logic            o_osc_enable,
   output logic            o_phase_clk,
   output logic            o_core_clk_en,
   output logic            o_periph_clk_en,
   output logic            o_sys_reset,
   output logic            o_sample_strobe,
   output logic [2:0]      o_state,
   output logic [7:0]      o_power_control_reg,
   output logic [7:0]      o_port_reset_value,
   output logic [7:0]      o_stack_reset_value,
   output logic [7:0]      o_sfr_reset_value,
   output logic            o_keep_serial_data_buffer,
   output logic            o_idle,
   output logic            o_power_down
);
   // =========================================================
   // Machine cycle timing
   // =========================================================
   logic       div_r;
   logic [2:0] state_r;
   cprc_pkg::cprc_mode_t mode_r;
   cprc_pkg::cprc_mode_t mode_nxt;
   logic [7:0] power_control_reg_r;
   logic       rst_r;
   logic       strobe_r;
   logic       filt_level;

   // Power-down freezes the divider and the state counter, and with them
   // the pin sampler. Only the power-on reset input therefore brings the
   // part out of power-down, so a wake-up reset must be routed there.
   wire clocks_on = (mode_r != cprc_pkg::CPRC_PD);

   // Halving makes internal phases independent of the input duty cycle.
   wire div_end   = div_r;
   wire state_end = (state_r == `CPRC_STATES_PER_CYCLE - 3'd1);

   // Phase 2 of state 5 is the second phase of the fifth state. The
   // decode is qualified by the running enable: with the counter frozen
   // it would otherwise stand high on every clock of power-down.
   wire sample_pt = clocks_on && div_end &&
                    (state_r == `CPRC_SAMPLE_STATE);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_r   <= 1'b0;
         state_r <= 3'h0;
      end else if (clocks_on) begin
         div_r <= ~div_r;
         if (div_end)
            state_r <= state_end ? 3'h0 : state_r + 3'h1;
      end
   end

   // =========================================================
   // Reset pin filter and internal reset
   // =========================================================
   // The pin must be seen high on two successive samples, so a pulse
   // shorter than one machine cycle can never reset the part.
   wire pin_sample = sample_pt;
   cprc_glitch_filter #(
      .N(int'(`CPRC_RST_HOLD_CYCLES))
   ) u_filter (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_sample(pin_sample),
      .i_level (i_rst_pin),
      .o_level (filt_level)
   );

   // Release is as slow as assertion: two low samples are needed, so a
   // dip in a held reset cannot let the core start half-way.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_r    <= 1'b1;
         strobe_r <= 1'b0;
      end else begin
         rst_r    <= filt_level;
         strobe_r <= pin_sample;
      end
   end

   // =========================================================
   // Power modes
   // =========================================================
   // A stopped core cannot write, so a strobe seen in power-down is dropped.
   wire power_control_reg_wr  = i_power_control_reg_we && clocks_on;
   wire idle_req = power_control_reg_wr && i_power_control_reg_wdata[`CPRC_POWER_CONTROL_REG_IDLE_BIT];
   wire pd_req   = power_control_reg_wr && i_power_control_reg_wdata[`CPRC_POWER_CONTROL_REG_PD_BIT];
   // Power-down wins over idle when both bits arrive in one write, and a
   // filtered reset overrides every request.

   always_comb begin
      mode_nxt = mode_r;
      unique case (mode_r)
         cprc_pkg::CPRC_RUN: begin
            if (pd_req)
               mode_nxt = cprc_pkg::CPRC_PD;
            else if (idle_req)
               mode_nxt = cprc_pkg::CPRC_IDLE;
         end
         cprc_pkg::CPRC_IDLE: begin
            if (i_irq)
               mode_nxt = cprc_pkg::CPRC_RUN;
         end
         cprc_pkg::CPRC_PD: begin
            mode_nxt = cprc_pkg::CPRC_PD;
         end
         default: mode_nxt = cprc_pkg::CPRC_RUN;
      endcase
      if (filt_level)
         mode_nxt = cprc_pkg::CPRC_RUN;
   end

   // Mode bits self-clear on leaving the mode; bit 4 is the power-on flag.
   // The flag is set whenever i_rst_n is asserted, so a wake-up reset from power-down sets it too.
   wire [7:0] power_control_reg_keep = power_control_reg_r & (8'h01 << `CPRC_POWER_CONTROL_REG_POF_BIT);
   wire       leaving   = (mode_nxt == cprc_pkg::CPRC_RUN) &&
                          (mode_r != cprc_pkg::CPRC_RUN);
   wire [7:0] mode_bits     = (8'h01 << `CPRC_POWER_CONTROL_REG_IDLE_BIT) |
                              (8'h01 << `CPRC_POWER_CONTROL_REG_PD_BIT);
   wire [7:0] power_control_reg_mode_clr = leaving ? mode_bits : 8'h00;

   // A reset outranks a write in the same cycle, and a write outranks the
   // self-clear of the mode bits.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_r <= cprc_pkg::CPRC_RUN;
         power_control_reg_r <= `CPRC_POWER_CONTROL_REG_RESET | (8'h01 << `CPRC_POWER_CONTROL_REG_POF_BIT);
      end else begin
         mode_r <= mode_nxt;
         if (filt_level)
            power_control_reg_r <= `CPRC_POWER_CONTROL_REG_RESET | power_control_reg_keep;
         else if (power_control_reg_wr)
            power_control_reg_r <= i_power_control_reg_wdata;
         else
            power_control_reg_r <= power_control_reg_r & ~power_control_reg_mode_clr;
      end
   end

   // =========================================================
   // Output decode
   // =========================================================
   // Enables and mode flags all come from the next mode, so they change on
   // the same edge; a lagging flag would show idle with the core running.
   wire osc_en_nxt    = (mode_nxt != cprc_pkg::CPRC_PD);
   wire core_en_nxt   = (mode_nxt == cprc_pkg::CPRC_RUN);
   wire periph_en_nxt = (mode_nxt != cprc_pkg::CPRC_PD);
   wire idle_nxt      = (mode_nxt == cprc_pkg::CPRC_IDLE);
   wire pd_nxt        = (mode_nxt == cprc_pkg::CPRC_PD);

   // =========================================================
   // Outputs
   // =========================================================
   // The reset values are held as constants so that the rest of the core
   // loads them for as long as o_sys_reset stands.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_osc_enable              <= 1'b1;
         o_phase_clk               <= 1'b0;
         o_core_clk_en             <= 1'b0;
         o_periph_clk_en           <= 1'b0;
         o_sys_reset               <= 1'b1;
         o_sample_strobe           <= 1'b0;
         o_state                   <= 3'h0;
         o_power_control_reg       <= 8'h00;
         o_port_reset_value        <= `CPRC_PORT_RESET;
         o_stack_reset_value       <= `CPRC_SP_RESET;
         o_sfr_reset_value         <= `CPRC_SFR_RESET;
         o_keep_serial_data_buffer <= 1'b1;
         o_idle                    <= 1'b0;
         o_power_down              <= 1'b0;
      end else begin
         o_osc_enable              <= osc_en_nxt;
         o_phase_clk               <= div_r;
         o_core_clk_en             <= core_en_nxt;
         o_periph_clk_en           <= periph_en_nxt;
         o_sys_reset               <= rst_r;
         o_sample_strobe           <= strobe_r;
         o_state                   <= state_r;
         o_power_control_reg       <= power_control_reg_r;
         o_port_reset_value        <= `CPRC_PORT_RESET;
         o_stack_reset_value       <= `CPRC_SP_RESET;
         o_sfr_reset_value         <= `CPRC_SFR_RESET;
         o_keep_serial_data_buffer <= 1'b1;
         o_idle                    <= idle_nxt;
         o_power_down              <= pd_nxt;
      end
   end
endmodule
`default_nettype wire

// [cprc_checker.sv]
// Port checks for the clock, power and reset control block.
`timescale 1ns/1ps
`default_nettype none
module cprc_checker (
   input wire logic       i_clk,
   input wire logic       i_rst_n,
   input wire logic       i_irq,
   input wire logic       o_osc_enable,
   input wire logic       o_phase_clk,
   input wire logic       o_core_clk_en,
   input wire logic       o_periph_clk_en,
   input wire logic       o_sys_reset,
   input wire logic       o_sample_strobe,
   input wire logic [2:0] o_state,
   input wire logic [7:0] o_power_control_reg,
   input wire logic [7:0] o_port_reset_value,
   input wire logic [7:0] o_stack_reset_value,
   input wire logic [7:0] o_sfr_reset_value,
   input wire logic       o_keep_serial_data_buffer,
   input wire logic       o_idle,
   input wire logic       o_power_down
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_port_ones: assert property (o_port_reset_value == 8'hFF)
      else $error("port reset value wrong");
   a_stack_seven: assert property (o_stack_reset_value == 8'h07)
      else $error("stack reset value wrong");
   a_sfr_zero: assert property (o_sfr_reset_value == 8'h00 &&
      o_keep_serial_data_buffer) else $error("register reset wrong");
   a_phase_halves: assert property (o_osc_enable && $past(o_osc_enable)
      && $past(i_rst_n, 2) |-> o_phase_clk != $past(o_phase_clk))
      else $error("no halving");
   a_sample_spacing: assert property (o_sample_strobe |=>
      !o_sample_strobe [*8]) else $error("samples too close");
   a_idle_gates: assert property (o_idle && $past(o_idle) |->
      !o_core_clk_en && o_periph_clk_en) else $error("idle gating wrong");
   a_idle_wakes: assert property (o_idle && i_irq |-> ##[1:3] !o_idle)
      else $error("interrupt did not end idle");
   a_pd_stops: assert property (o_power_down && $past(o_power_down) |->
      !o_osc_enable && !o_periph_clk_en && !o_core_clk_en)
      else $error("clock running in power-down");
   a_pd_holds: assert property (o_power_down |=> o_power_down)
      else $error("power-down left without reset");
   a_state_range: assert property (o_state < 3'h6)
      else $error("machine state out of range");
   a_rst_clears: assert property (o_sys_reset && $past(o_sys_reset, 2)
      |-> {o_power_control_reg[7:5], o_power_control_reg[3:0]} == 7'h00)
      else $error("power_control_reg not cleared");
   cover property (o_idle && i_irq);
   cover property ($rose(o_sys_reset));
   cover property (o_power_down && i_irq);
endmodule
bind cprc_top cprc_checker u_chk (.*);
`default_nettype wire

// [cprc_reset_net.sv]
// Model of the external reset network that drives the reset pin.
`timescale 1ns/1ps
`default_nettype none
module cprc_reset_net (
   input  wire logic i_clk,
   input  wire logic i_hold,
   input  wire logic i_glitch,
   output var logic  o_rst_pin
);
   initial o_rst_pin = 1'b0;
   // The pin lags the bench by one clock; the bench decides how long a
   // hold or a glitch stands.
   always @(posedge i_clk) o_rst_pin <= i_hold | i_glitch;
endmodule
`default_nettype wire

// [cprc_top_tb.sv]
// Self-checking bench for the clock, power and reset control block.
`timescale 1ns/1ps
`default_nettype none
module cprc_top_tb;
   logic clk = 0, rst_n = 0, we = 0, irq = 0, hold = 0, glitch = 0;
   logic [7:0] wd = 8'h00;
   int fail_count = 0, n_checks = 0;
   wire logic pin, osc, ph, core, peri, srst, strb, idle, pd, keep;
   wire logic [2:0] st;
   wire logic [7:0] power_control_reg, pv, spv, sfv;
   cprc_reset_net net (.i_clk(clk), .i_hold(hold), .i_glitch(glitch),
      .o_rst_pin(pin));
   cprc_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_rst_pin(pin),
      .i_power_control_reg_we(we), .i_power_control_reg_wdata(wd), .i_irq(irq), .o_osc_enable(osc),
      .o_phase_clk(ph), .o_core_clk_en(core), .o_periph_clk_en(peri),
      .o_sys_reset(srst), .o_sample_strobe(strb), .o_state(st),
      .o_power_control_reg(power_control_reg), .o_port_reset_value(pv),
      .o_stack_reset_value(spv), .o_sfr_reset_value(sfv),
      .o_keep_serial_data_buffer(keep), .o_idle(idle), .o_power_down(pd));
   always #25 clk = ~clk;
   // =========================================================
   // Helpers
   task automatic chk(input string nm, input logic [7:0] s, e);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] d);
      we = 1;
      wd = d;
      cyc(1);
      we = 0;
   endtask
   // Two samples twelve clocks apart plus pipeline fit well inside 60.
   task automatic wait_rst(input logic v);
      for (int i = 0; i < 60 && srst !== v; i++) cyc(1);
      chk("sys_reset", 8'(srst), 8'(v));
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // =========================================================
   // Scenarios
   // The strobe trails the sample by two clocks and the state output by
   // one, so while it stands the state after the fifth is shown.
   task automatic t_cycle;
      int n;
      n = 0;
      while (strb !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      chk("state", 8'(st), 8'h05);
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (strb !== 1'b1 && n < 20);
      chk("cycle", 8'(n), 8'h0C);
      $display("machine cycle test done");
   endtask
   task automatic t_idle;
      wr(8'h01);
      cyc(3);
      chk("idle", 8'(idle), 8'h01);
      chk("core_en", 8'(core), 8'h00);
      chk("periph_en", 8'(peri), 8'h01);
      irq = 1;
      cyc(1);
      irq = 0;
      cyc(3);
      chk("core_en", 8'(core), 8'h01);
      chk("idle", 8'(idle), 8'h00);
      $display("idle test done");
   endtask
   // One machine cycle high always spans exactly one sample point.
   task automatic t_glitch;
      logic seen;
      seen = 1'b0;
      glitch = 1;
      for (int i = 0; i < 40; i++) begin
         if (i == 12) glitch = 0;
         cyc(1);
         seen = seen | srst;
      end
      chk("sys_reset", 8'(seen), 8'h00);
      $display("glitch test done");
   endtask
   task automatic t_pin(input logic [7:0] flag);
      wr(flag);
      cyc(1);
      chk("power_control_reg", power_control_reg, flag);
      hold = 1;
      wait_rst(1);
      cyc(3);
      chk("power_control_reg", power_control_reg, flag & 8'h10);
      chk("ports", pv, 8'hFF);
      chk("stack", spv, 8'h07);
      chk("sfr", sfv, 8'h00);
      hold = 0;
      wait_rst(0);
      $display("pin reset test done");
   endtask
   task automatic t_pd;
      wr(8'h03);
      cyc(3);
      chk("power_down", 8'(pd), 8'h01);
      chk("osc", 8'(osc), 8'h00);
      chk("core_en", 8'(core), 8'h00);
      chk("periph_en", 8'(peri), 8'h00);
      irq = 1;
      cyc(4);
      irq = 0;
      chk("power_down", 8'(pd), 8'h01);
      rst_n = 0;
      cyc(2);
      rst_n = 1;
      cyc(3);
      chk("power_down", 8'(pd), 8'h00);
      chk("power_control_reg", power_control_reg, 8'h10);
      $display("power-down test done");
   endtask
   initial begin
      cyc(6);
      rst_n = 1;
      cyc(2);
      chk("power_control_reg", power_control_reg, 8'h10);
      t_cycle;
      t_idle;
      t_glitch;
      t_pin(8'h0C);
      t_pin(8'h1C);
      t_pd;
      tally_and_finish;
   end
   initial begin
      #(2000 * 50);
      fail_count++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
